// ==== shared/twcp_pkg.sv ====
// constants for the three-wire configuration port
package twcp_pkg;
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] DIR_BIT_CNT = 5'h07; // D15-D9 held, D8 arriving
    localparam logic [4:0] TURN_BIT_CNT = 5'h08; // D8 slot, read drive starts
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 10;
    localparam int DIR_POS = 9;
    // register offsets
    localparam logic [5:0] SYSCTL_MAIN_ADDR = 6'h00;
    localparam logic [5:0] SYSCTL_FORMAT_ADDR = 6'h01;
    // reset values and writable masks
    localparam logic [7:0] SYSCTL_MAIN_RST = 8'h2D;
    localparam logic [7:0] SYSCTL_MAIN_MASK = 8'hBF;
    localparam logic [7:0] SYSCTL_FORMAT_RST = 8'h00;
    localparam logic [7:0] SYSCTL_FORMAT_MASK = 8'hFE;
    // field positions in system_control_main
    localparam int MAIN_DE_MODE = 0;
    localparam int MAIN_PIXEL_EDGE = 1;
    localparam int MAIN_GLOBAL_RESET_N = 2;
    localparam int MAIN_STANDBY_N = 3;
    localparam int MAIN_SCAN_DIR = 4;
    localparam int MAIN_SHIFT_DIR = 5;
    localparam int MAIN_POWER_EN = 7;
    // field positions in system_control_format
    localparam int FMT_RES_LO = 1;
    localparam int FMT_RES_HI = 2;
    localparam int FMT_SELF_TEST = 3;
    localparam int FMT_DITHER = 4;
    localparam int FMT_HORIZONTAL_FRAME_RATE_CTL = 5;
    localparam int FMT_ABL_LO = 6;
    localparam int FMT_ABL_HI = 7;
    // panel formats
    localparam logic [1:0] RES_1024X600 = 2'h0;
    localparam logic [1:0] RES_1024X768 = 2'h1;
    localparam logic [1:0] RES_800X600 = 2'h2;
    localparam logic [1:0] RES_800X480 = 2'h3;
endpackage : twcp_pkg

// ==== core/twcp_sync2.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ns
module twcp_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // level in and out
    input wire logic i_d,
    output logic o_q
);
    logic stage1;
    logic stage2;

    // first stage is read only by the second
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1 <= RST_VAL;
            stage2 <= RST_VAL;
        end else begin
            stage1 <= i_d;
            stage2 <= stage1;
        end
    end

    assign o_q = stage2;
endmodule : twcp_sync2

// ==== core/twcp_port.sv ====
// three-wire configuration port and its two system control registers
`timescale 1ns/1ns
module twcp_port (
    // system clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // serial link
    input wire logic i_serial_clk,
    input wire logic i_port_select_n,
    input wire logic i_sdata,
    output logic o_sdata,
    output logic o_sdata_oe,
    // main control fields
    output logic o_de_mode,
    output logic o_pixel_edge_select,
    output logic o_global_reset_n,
    output logic o_standby_n,
    output logic o_vertical_scan_dir,
    output logic o_gate_direction_out,
    output logic o_first_start_sel,
    output logic o_second_start_sel,
    output logic o_source_shift_dir,
    output logic o_power_stage_enable,
    // format control fields
    output logic [1:0] o_panel_format,
    output logic o_channel_block_off,
    output logic o_self_test_pattern,
    output logic o_dither_en,
    output logic o_horizontal_frame_rate_ctl,
    output logic [1:0] o_adaptive_backlight_mode
);
    ////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta;
    logic rst_n;

    // async assert, synchronous release
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link side: shifter on the serial clock
    // select high acts as the link-side reset, since the serial clock
    // stops between frames and cannot be relied on to clear state
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [15:0] shreg;
    logic [15:0] next_shreg;
    logic [7:0] rd_shift;
    logic [7:0] next_rd_shift;
    logic rd_mode;
    logic next_rd_mode;
    logic [7:0] rd_byte;

    // read byte chosen from the registers, stable while a frame runs
    logic [7:0] main_reg;
    logic [7:0] fmt_reg;

    // shifter next state
    always_comb begin
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_rd_shift = rd_shift;
        next_rd_mode = rd_mode;
        next_shreg = {shreg[14:0], i_sdata};
        if (bit_cnt != 5'h1F) begin
            next_bit_cnt = bit_cnt + 5'h01;
        end
        // direction latched as D8 arrives, D9 sits in bit 0
        if (bit_cnt == twcp_pkg::DIR_BIT_CNT) begin
            next_rd_mode = shreg[0];
            // address taken from the first six bits
            next_rd_shift = sel_byte(shreg[6:1]);
        end else if (rd_mode && bit_cnt >= twcp_pkg::TURN_BIT_CNT) begin
            next_rd_shift = {rd_shift[6:0], 1'b0};
        end
    end

    function automatic logic [7:0] sel_byte(input logic [5:0] a);
        if (a == twcp_pkg::SYSCTL_MAIN_ADDR) begin
            sel_byte = main_reg;
        end else if (a == twcp_pkg::SYSCTL_FORMAT_ADDR) begin
            sel_byte = fmt_reg;
        end else begin
            sel_byte = 8'h00;
        end
    endfunction : sel_byte

    always_ff @(posedge i_serial_clk or posedge i_port_select_n) begin
        if (i_port_select_n) begin
            bit_cnt <= 5'h00;
            shreg <= 16'h0000;
            rd_shift <= 8'h00;
            rd_mode <= 1'b0;
        end else begin
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            rd_shift <= next_rd_shift;
            rd_mode <= next_rd_mode;
        end
    end
    assign rd_byte = rd_shift;

    ////////////////////////////////////////////////////////////////////
    // read driver, changes on falling serial clock
    logic drv_en;
    logic drv_bit;

    // drive data phase; turnaround slot stays undriven
    always_ff @(negedge i_serial_clk or posedge i_port_select_n) begin
        if (i_port_select_n) begin
            drv_en <= 1'b0;
            drv_bit <= 1'b0;
        end else begin
            // first drive on the falling edge right after the D8 slot
            drv_en <= rd_mode && bit_cnt >= twcp_pkg::TURN_BIT_CNT
                && bit_cnt < twcp_pkg::FRAME_LEN;
            drv_bit <= rd_byte[7];
        end
    end

    // controller samples on rising edge after this falling-edge drive
    assign o_sdata = drv_en ? drv_bit : 1'b0;
    assign o_sdata_oe = drv_en;

    ////////////////////////////////////////////////////////////////////
    // crossing: frame end event into the system clock
    // the capture register loads only on the serial clock, which stops while select is high, so the captured
    // frame is stable until the next frame begins; the synchronised
    // select edge gives the system side time to copy it
    logic sel_sync;
    logic sel_prev;
    logic [15:0] cap_frame;
    logic [4:0] cap_cnt;
    logic [15:0] next_cap_frame;
    logic [4:0] next_cap_cnt;
    logic frame_end;

    twcp_sync2 #(
        .RST_VAL(1'b1)
    ) u_sel_sync (
        .i_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .i_d(i_port_select_n),
        .o_q(sel_sync)
    );

    // track the shifter while select is low, hold last frame while high, on falling serial clock side
    always_comb begin
        next_cap_frame = cap_frame;
        next_cap_cnt = cap_cnt;
        if (!i_port_select_n) begin
            next_cap_frame = shreg;
            next_cap_cnt = bit_cnt;
        end
    end

    // capture register on the link clock so it never changes at deselect
    always_ff @(negedge i_serial_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_frame <= 16'h0000;
            cap_cnt <= 5'h00;
        end else begin
            cap_frame <= next_cap_frame;
            cap_cnt <= next_cap_cnt;
        end
    end

    assign frame_end = sel_sync && !sel_prev;

    ////////////////////////////////////////////////////////////////////
    // register file on the system clock
    logic [7:0] next_main_reg;
    logic [7:0] next_fmt_reg;
    logic next_sel_prev;
    logic wr_ok;

    // only an exact 16-bit write frame commits
    assign wr_ok = frame_end && cap_cnt == twcp_pkg::FRAME_LEN
        && !cap_frame[twcp_pkg::DIR_POS];

    // commit at deselect, reserved bits masked
    always_comb begin
        next_main_reg = main_reg;
        next_fmt_reg = fmt_reg;
        next_sel_prev = sel_sync;
        if (wr_ok) begin
            case (cap_frame[twcp_pkg::ADDR_HI:twcp_pkg::ADDR_LO])
                twcp_pkg::SYSCTL_MAIN_ADDR: begin
                    next_main_reg = cap_frame[7:0]
                        & twcp_pkg::SYSCTL_MAIN_MASK;
                end
                twcp_pkg::SYSCTL_FORMAT_ADDR: begin
                    next_fmt_reg = cap_frame[7:0]
                        & twcp_pkg::SYSCTL_FORMAT_MASK;
                end
                default: begin
                    next_main_reg = main_reg;
                end
            endcase
        end
    end

    // register storage
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            main_reg <= twcp_pkg::SYSCTL_MAIN_RST;
            fmt_reg <= twcp_pkg::SYSCTL_FORMAT_RST;
            sel_prev <= 1'b1;
        end else begin
            main_reg <= next_main_reg;
            fmt_reg <= next_fmt_reg;
            sel_prev <= next_sel_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // field decode, all from flip-flops
    // timing mode
    assign o_de_mode = main_reg[twcp_pkg::MAIN_DE_MODE];
    assign o_pixel_edge_select = main_reg[twcp_pkg::MAIN_PIXEL_EDGE];
    assign o_global_reset_n = main_reg[twcp_pkg::MAIN_GLOBAL_RESET_N];
    assign o_standby_n = main_reg[twcp_pkg::MAIN_STANDBY_N];
    // scan direction and start pulse choice
    assign o_vertical_scan_dir = main_reg[twcp_pkg::MAIN_SCAN_DIR];
    assign o_gate_direction_out = main_reg[twcp_pkg::MAIN_SCAN_DIR];
    assign o_first_start_sel = main_reg[twcp_pkg::MAIN_SCAN_DIR];
    assign o_second_start_sel = !main_reg[twcp_pkg::MAIN_SCAN_DIR];
    assign o_source_shift_dir = main_reg[twcp_pkg::MAIN_SHIFT_DIR];
    assign o_power_stage_enable = main_reg[twcp_pkg::MAIN_POWER_EN];
    assign o_panel_format =
        fmt_reg[twcp_pkg::FMT_RES_HI:twcp_pkg::FMT_RES_LO];
    assign o_channel_block_off = fmt_reg[twcp_pkg::FMT_RES_HI];
    assign o_self_test_pattern = fmt_reg[twcp_pkg::FMT_SELF_TEST];
    assign o_dither_en = fmt_reg[twcp_pkg::FMT_DITHER];
    assign o_horizontal_frame_rate_ctl = fmt_reg[twcp_pkg::FMT_HORIZONTAL_FRAME_RATE_CTL]
        & fmt_reg[twcp_pkg::FMT_DITHER];
    assign o_adaptive_backlight_mode =
        fmt_reg[twcp_pkg::FMT_ABL_HI:twcp_pkg::FMT_ABL_LO];

    ////////////////////////////////////////////////////////////////////
    // checks on the system clock, the link drive check on the falling serial clock
    // short or long frames never change the registers
    bad_len_keep_a: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        (frame_end && cap_cnt != twcp_pkg::FRAME_LEN)
        |=> $stable(main_reg) && $stable(fmt_reg))
        else $error("odd length frame changed a register");
    read_no_write_a: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        (frame_end && cap_frame[twcp_pkg::DIR_POS])
        |=> $stable(main_reg) && $stable(fmt_reg))
        else $error("read frame changed a register");
    reserved_zero_a: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        !main_reg[6] && !fmt_reg[0])
        else $error("reserved bit set");
    // a good write to the main register lands its masked data byte next cycle
    write_lands_a: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        (wr_ok && cap_frame[15:10] == twcp_pkg::SYSCTL_MAIN_ADDR)
        |=> main_reg == ($past(cap_frame[7:0])
        & twcp_pkg::SYSCTL_MAIN_MASK))
        else $error("write did not land in main register");
    // registers only change at a frame end
    change_at_end_a: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        !$past(wr_ok) |-> $stable(main_reg) && $stable(fmt_reg))
        else $error("register changed without a write");
    start_excl_a: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        o_first_start_sel != o_second_start_sel)
        else $error("both start outputs selected");
    frc_dither_a: assert property (@(posedge i_ref_clk)
        disable iff (!rst_n)
        !o_dither_en |-> !o_horizontal_frame_rate_ctl)
        else $error("frc on without dithering");
    // link drive only during a read
    drive_read_a: assert property (@(negedge i_serial_clk)
        disable iff (i_port_select_n)
        o_sdata_oe |-> rd_mode)
        else $error("data driven outside a read");
endmodule : twcp_port

// ==== sim/twcp_ctl_model.sv ====
// behavioural external controller that drives the three-wire port
`timescale 1ns/1ns
module twcp_ctl_model (
    // serial link toward the port
    output logic o_serial_clk,
    output logic o_port_select_n,
    output logic o_sdata,
    // data returned by the port
    input wire logic i_sdata,
    input wire logic i_sdata_oe
);
    logic drv_oe;
    logic drv_d;
    logic last_v;

    ////////////////////////////////////////////////////////////////////////
    // idle state: clock parked low, port deselected, line driven low
    initial begin
        o_serial_clk = 1'b0;
        o_port_select_n = 1'b1;
        drv_oe = 1'b1;
        drv_d = 1'b0;
        last_v = 1'b0;
    end

    // wire level; with no pull on the line an undriven bit shows the
    // inverse of the last one so a stale value is never read as good
    assign o_sdata = i_sdata_oe ? i_sdata : (drv_oe ? drv_d : ~last_v);

    // remember the last settled level for the undriven case
    always @(posedge o_serial_clk) begin
        last_v <= o_sdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // one frame of nbits bits; a clock edge only runs inside the frame
    // whole frame while selected
    task automatic xfer(input logic [15:0] frame, input int nbits,
                        output logic [7:0] rdata);
        logic [16:0] sh;
        int i;
        sh = {frame, 1'b0};
        rdata = 8'h00;
        o_port_select_n = 1'b0;
        #62;
        for (i = 0; i < nbits; i++) begin
            // msb first, changed while clock low
            drv_d = sh[16];
            sh = sh << 1;
            // float from turnaround slot on reads
            drv_oe = !(frame[9] && i >= 7);
            #62 o_serial_clk = 1'b1;
            // capture returned bits on rising edge
            if (i >= 8) begin
                rdata = {rdata[6:0], o_sdata};
            end
            #63 o_serial_clk = 1'b0;
        end
        #100;
        o_port_select_n = 1'b1;
        drv_oe = 1'b1;
        // gap well above the minimum deselect time, also covers commit
        #250;
    endtask : xfer
endmodule : twcp_ctl_model

// ==== sim/test_three_wire_config_port.sv ====
// self-checking bench for the three-wire configuration port
`timescale 1ns/1ns
module test_three_wire_config_port;
    logic i_ref_clk;
    logic i_arst_n;
    logic serial_clk;
    logic port_select_n;
    logic line;
    logic sdata_out;
    logic sdata_oe;
    logic de_mode;
    logic pixel_edge;
    logic grst_n;
    logic standby_n;
    logic scan_dir;
    logic gate_dir;
    logic first_sel;
    logic second_sel;
    logic shift_dir;
    logic power_en;
    logic [1:0] panel_format;
    logic block_off;
    logic self_test;
    logic dither_en;
    logic frc_en;
    logic [1:0] abl_mode;
    int fails;
    int num_checks;
    logic [7:0] rd;

    ////////////////////////////////////////////////////////////////////////
    // design and controller model
    twcp_port dut_u (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
        .i_serial_clk(serial_clk), .i_port_select_n(port_select_n),
        .i_sdata(line), .o_sdata(sdata_out), .o_sdata_oe(sdata_oe),
        .o_de_mode(de_mode), .o_pixel_edge_select(pixel_edge),
        .o_global_reset_n(grst_n), .o_standby_n(standby_n),
        .o_vertical_scan_dir(scan_dir), .o_gate_direction_out(gate_dir),
        .o_first_start_sel(first_sel), .o_second_start_sel(second_sel),
        .o_source_shift_dir(shift_dir), .o_power_stage_enable(power_en),
        .o_panel_format(panel_format), .o_channel_block_off(block_off),
        .o_self_test_pattern(self_test), .o_dither_en(dither_en),
        .o_horizontal_frame_rate_ctl(frc_en),
        .o_adaptive_backlight_mode(abl_mode)
    );
    twcp_ctl_model ctl_u (
        .o_serial_clk(serial_clk), .o_port_select_n(port_select_n),
        .o_sdata(line), .i_sdata(sdata_out), .i_sdata_oe(sdata_oe)
    );

    // 50 MHz system clock
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // compare and report helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [7:0] d, input int n);
        ctl_u.xfer({a, 1'b0, 1'b0, d}, n, rd);
    endtask : wr

    task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
        ctl_u.xfer({a, 1'b1, 1'b0, 8'h00}, 16, rd);
        chk({8'h00, rd}, {8'h00, exp});
    endtask : rdchk

    // main fields, bit 4 fans out to scan, gate and start selection
    task automatic chk_main(input logic [7:0] v);
        chk({6'h00, power_en, shift_dir, scan_dir, gate_dir, first_sel,
             second_sel, standby_n, grst_n, pixel_edge, de_mode},
            {6'h00, v[7], v[5], v[4], v[4], v[4], ~v[4], v[3:0]});
    endtask : chk_main

    // format fields, frc only with dithering, 800 wide blocks channels
    task automatic chk_fmt(input logic [7:0] v);
        chk({8'h00, abl_mode, frc_en, dither_en, self_test, block_off,
             panel_format},
            {8'h00, v[7:6], v[5] & v[4], v[4], v[3], v[2], v[2:1]});
    endtask : chk_fmt

    task automatic summarize;
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////
    // watchdog, about ten times the expected run length
    initial begin
        #500000;
        fails++;
        summarize();
    end

    // test sequence
    initial begin
        logic [2:0] k;
        logic [7:0] v;
        fails = 0;
        num_checks = 0;
        i_arst_n = 1'b0;
        repeat (6) @(negedge i_ref_clk);
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        chk_main(8'h2D);
        chk_fmt(8'h00);
        rdchk(6'h00, 8'h2D);
        rdchk(6'h01, 8'h00);
        // reserved bit stays zero on write
        wr(6'h00, 8'hFF, 16);
        chk_main(8'hBF);
        rdchk(6'h00, 8'hBF);
        wr(6'h00, 8'h00, 16);
        chk_main(8'h00);
        // short and long frames must not write
        wr(6'h00, 8'hFF, 15);
        chk_main(8'h00);
        wr(6'h00, 8'hFF, 17);
        chk_main(8'h00);
        // turnaround bit set during a write is ignored
        ctl_u.xfer({6'h00, 1'b0, 1'b1, 8'h96}, 16, rd);
        chk_main(8'h96);
        // unmapped address writes nothing and reads zero
        wr(6'h05, 8'h55, 16);
        chk_main(8'h96);
        chk_fmt(8'h00);
        rdchk(6'h05, 8'h00);
        // every panel format and backlight code, frc gating cases
        for (k = 3'h0; k < 3'h4; k++) begin
            v = {k[1:0], k[0], k[1], k[0], k[1:0], 1'b1};
            wr(6'h01, v, 16);
            chk_fmt(v);
            rdchk(6'h01, v & 8'hFE);
        end
        // reset in mid-run restores the defaults
        @(negedge i_ref_clk);
        i_arst_n = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        chk_main(8'h2D);
        chk_fmt(8'h00);
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        rdchk(6'h00, 8'h2D);
        summarize();
    end
endmodule : test_three_wire_config_port
